//--- rtl/tdg_pkg.sv
// Shared constants and carrier types for the deadtime gate logic
package tdg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 50;
  localparam int DT_STEP_NS       = 50;
  localparam int DT_MAX_NS        = 12000;
  localparam int DT_MAX_STEPS     = DT_MAX_NS / DT_STEP_NS;
  localparam int DT_STEP_CYC      = (DT_STEP_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
  localparam logic [7:0] DT_CNT_MIN   = 8'h01;
  localparam logic [7:0] DT_CNT_MAX   = 8'hFF;
  localparam logic [7:0] DT_RESET_VAL = 8'h10;
  localparam logic [7:0] CAL_RESET_VAL = 8'h00;
  localparam logic [3:0] BLANK_CYC    = 4'h8;

  // ----------------------------------------------------------------
  // Commands and carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TDG_CMD_NONE,
    TDG_CMD_DEADTIME,
    TDG_CMD_CAL,
    TDG_CMD_MODE,
    TDG_CMD_MASK,
    TDG_CMD_SIM_ARM,
    TDG_CMD_SIM_SET
  } tdg_cmd_e;

  typedef struct packed {
    logic full_on_bypass_mode;
    logic desat_shutdown_off;
    logic zero_deadtime;
  } tdg_mode_s;

  typedef struct packed {
    logic [2:0] hs;
    logic [2:0] ls;
  } tdg_gate_s;

  typedef struct packed {
    logic       sim_enabled;
    logic       sim_used;
    logic       mode_locked;
    logic [2:0] boot_ready;
    logic       blanking;
    logic [7:0] dt_cycles;
  } tdg_status_s;

endpackage

//--- rtl/tdg_sync.sv
// Two flip-flop synchroniser for the phase input pins
`timescale 1ns/1ns
module tdg_sync #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

//--- rtl/tdg_phase.sv
// One phase: edge detect, deadtime timer, bootstrap interlock
`timescale 1ns/1ns
module tdg_phase (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       hs_in,
  input  wire logic       ls_in,
  input  wire logic [7:0] dt_cycles,
  input  wire logic       zero_dt,
  input  wire logic       sim_en,
  output logic            hs_cmd,
  output logic            ls_cmd,
  output logic            boot_ok,
  output logic            turn_on
);

  logic       hs_d_r;
  logic       ls_d_r;
  logic [7:0] dt_cnt_r;
  logic       hs_rise;
  logic       ls_rise;
  logic       hs_fall;
  logic       ls_fall;
  logic       dt_busy;
  logic       hs_want;
  logic       ls_want;

  assign hs_rise = hs_in & ~hs_d_r;
  assign ls_rise = ls_in & ~ls_d_r;
  assign hs_fall = ~hs_in & hs_d_r;
  assign ls_fall = ~ls_in & ls_d_r;
  assign dt_busy = (dt_cnt_r != 8'h00);

  // Requested levels; leading edge of one side kills the other
  always_comb begin
    hs_want = hs_in & ~(ls_rise & ~sim_en);
    ls_want = ls_in & ~(hs_rise & ~sim_en);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hs_d_r <= 1'b0;
      ls_d_r <= 1'b0;
    end else begin
      hs_d_r <= hs_in;
      ls_d_r <= ls_in;
    end
  end

  // Deadtime timer restarts at every turn-off
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dt_cnt_r <= 8'h00;
    end else if ((hs_cmd & ~hs_want) | (ls_cmd & ~ls_want)) begin
      dt_cnt_r <= zero_dt ? 8'h00 : dt_cycles;
    end else if (dt_busy) begin
      dt_cnt_r <= dt_cnt_r - 8'h01;
    end
  end

  // Bootstrap interlock: low side must have been on once
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      boot_ok <= 1'b0;
    end else if (ls_cmd) begin
      boot_ok <= 1'b1;
    end
  end

  // Gate decisions
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hs_cmd  <= 1'b0;
      ls_cmd  <= 1'b0;
      turn_on <= 1'b0;
    end else begin
      hs_cmd  <= hs_want & boot_ok & ~dt_busy
                 & (sim_en | ~(ls_want | ls_cmd));
      ls_cmd  <= ls_want & ~dt_busy
                 & (sim_en | ~(hs_want | hs_cmd));
      turn_on <= (hs_want & ~hs_cmd) | (ls_want & ~ls_cmd)
                 | hs_rise | ls_rise | hs_fall | ls_fall;
    end
  end

  sequence s_idle_busy;
    dt_busy && !hs_cmd && !ls_cmd;
  endsequence

  property p_no_overlap;
    @(posedge clk) disable iff (!resetn)
      !sim_en |-> !(hs_cmd && ls_cmd);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("Both gates of a phase on");

  property p_boot;
    @(posedge clk) disable iff (!resetn)
      hs_cmd |-> $past(boot_ok);
  endproperty
  a_boot: assert property (p_boot)
    else $error("High side on before bootstrap");

  property p_dt_block;
    @(posedge clk) disable iff (!resetn)
      s_idle_busy |=> !hs_cmd && !ls_cmd;
  endproperty
  a_dt_block: assert property (p_dt_block)
    else $error("Gate turned on during deadtime");

endmodule

//--- rtl/tdg_top.sv
// Three-phase deadtime gate control logic
// ----------------------------------------------------------------
// Notes on behaviour
// - Deadtime programmable in 50 ns steps from 50 ns to 12.75 us.
// - Deadtime counted in clock cycles 1..255; larger values saturate.
// - Deadtime calibration offset set by command.
// - Simultaneous conduction enabled disables blanking.
// - Simultaneous-enable command accepted only once per reset.
// - Full-on, desaturation and zero-deadtime modes settable then locked.
// - Fault reporting selectable per source by command.
// - Status readable by the controller.
// - Leading edge kills complement at once, turns on after deadtime.
// - Deadtime timer starts at each turn-off, holds complement off.
// - Turn-on after elapsed deadtime executes without delay.
// - Full-on mode bypasses decision stage, one cycle less latency.
// - High side refused until same-phase low side enabled once.
// - Current limit blanked after each input change.
// - Blanking applied to all phases when any switch turns on.
// ----------------------------------------------------------------
`timescale 1ns/1ns
module tdg_top (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [2:0]       phase_high_side_input,
  input  wire logic [2:0]       phase_low_side_input,
  input  wire logic             cmd_valid,
  input  wire tdg_pkg::tdg_cmd_e cmd_op,
  input  wire logic [7:0]       cmd_data,
  input  wire logic [3:0]       fault_in,
  output tdg_pkg::tdg_gate_s    gate_out,
  output logic                  blank_out,
  output logic [3:0]            fault_report,
  output tdg_pkg::tdg_status_s  status_out
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [5:0]          pin_sync;
  logic [2:0]          hs_s;
  logic [2:0]          ls_s;
  tdg_pkg::tdg_gate_s  sm_gate;
  tdg_pkg::tdg_mode_s  mode_r;
  logic                mode_lock_r;
  logic [7:0]          dt_step_r;
  logic [7:0]          cal_r;
  logic [7:0]          dt_cyc_r;
  logic [8:0]          dt_sum;
  logic [3:0]          mask_r;
  logic                sim_arm_r;
  logic                sim_used_r;
  logic                sim_en_r;
  logic [2:0]          boot_ok;
  logic [2:0]          ph_on;
  logic [3:0]          blank_cnt_r;

  tdg_sync #(.W(6)) tdg_sync_i (
    .clk    (clk),
    .resetn (resetn),
    .d      ({phase_high_side_input, phase_low_side_input}),
    .q      (pin_sync)
  );

  assign hs_s = pin_sync[5:3];
  assign ls_s = pin_sync[2:0];

  // ----------------------------------------------------------------
  // Configuration commands
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dt_step_r <= tdg_pkg::DT_RESET_VAL;
      cal_r     <= tdg_pkg::CAL_RESET_VAL;
    end else if (cmd_valid && cmd_op == tdg_pkg::TDG_CMD_DEADTIME) begin
      dt_step_r <= cmd_data;
    end else if (cmd_valid && cmd_op == tdg_pkg::TDG_CMD_CAL) begin
      cal_r <= cmd_data;
    end
  end

  // Steps plus calibration, clipped to the counter range
  assign dt_sum = {1'b0, dt_step_r} + {1'b0, cal_r};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dt_cyc_r <= tdg_pkg::DT_CNT_MIN;
    end else if (dt_sum[8]) begin
      dt_cyc_r <= tdg_pkg::DT_CNT_MAX;
    end else if (dt_sum[7:0] == 8'h00) begin
      dt_cyc_r <= tdg_pkg::DT_CNT_MIN;
    end else begin
      dt_cyc_r <= dt_sum[7:0];
    end
  end

  // Mode bits, locked by bit 7 of the mode command
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_r      <= '0;
      mode_lock_r <= 1'b0;
    end else if (cmd_valid && cmd_op == tdg_pkg::TDG_CMD_MODE
                 && !mode_lock_r) begin
      mode_r      <= cmd_data[2:0];
      mode_lock_r <= cmd_data[7];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mask_r <= 4'h0;
    end else if (cmd_valid && cmd_op == tdg_pkg::TDG_CMD_MASK) begin
      mask_r <= cmd_data[3:0];
    end
  end

  // Simultaneous mode: arm then set, once per reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sim_arm_r  <= 1'b0;
      sim_used_r <= 1'b0;
      sim_en_r   <= 1'b0;
    end else if (cmd_valid) begin
      if (cmd_op == tdg_pkg::TDG_CMD_SIM_ARM) begin
        sim_arm_r <= 1'b1;
      end else if (cmd_op == tdg_pkg::TDG_CMD_SIM_SET && sim_arm_r
                   && !sim_used_r) begin
        sim_en_r   <= cmd_data[0];
        sim_used_r <= 1'b1;
        sim_arm_r  <= 1'b0;
      end else begin
        sim_arm_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Phase logic
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ph
      tdg_phase tdg_phase_i (
        .clk       (clk),
        .resetn    (resetn),
        .hs_in     (hs_s[g]),
        .ls_in     (ls_s[g]),
        .dt_cycles (dt_cyc_r),
        .zero_dt   (mode_r.zero_deadtime),
        .sim_en    (sim_en_r),
        .hs_cmd    (sm_gate.hs[g]),
        .ls_cmd    (sm_gate.ls[g]),
        .boot_ok   (boot_ok[g]),
        .turn_on   (ph_on[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gate_out <= '0;
    end else if (mode_r.full_on_bypass_mode) begin
      gate_out.hs <= hs_s & boot_ok & (~ls_s | {3{sim_en_r}});
      gate_out.ls <= ls_s & (~hs_s | {3{sim_en_r}});
    end else begin
      gate_out <= sm_gate;
    end
  end

  // Blanking shared by all phases
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      blank_cnt_r <= 4'h0;
    end else if (sim_en_r) begin
      blank_cnt_r <= 4'h0;
    end else if (|ph_on) begin
      blank_cnt_r <= tdg_pkg::BLANK_CYC;
    end else if (blank_cnt_r != 4'h0) begin
      blank_cnt_r <= blank_cnt_r - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      blank_out    <= 1'b0;
      fault_report <= 4'h0;
    end else begin
      blank_out    <= (blank_cnt_r != 4'h0);
      fault_report <= fault_in & mask_r
                      & {4{blank_cnt_r == 4'h0}};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_out <= '0;
    end else begin
      status_out.sim_enabled <= sim_en_r;
      status_out.sim_used    <= sim_used_r;
      status_out.mode_locked <= mode_lock_r;
      status_out.boot_ready  <= boot_ok;
      status_out.blanking    <= (blank_cnt_r != 4'h0);
      status_out.dt_cycles   <= dt_cyc_r;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_mode_cmd;
    cmd_valid && cmd_op == tdg_pkg::TDG_CMD_MODE && !mode_lock_r;
  endsequence

  sequence s_sim_arm;
    cmd_valid && cmd_op == tdg_pkg::TDG_CMD_SIM_ARM;
  endsequence

  sequence s_sim_set;
    cmd_valid && cmd_op == tdg_pkg::TDG_CMD_SIM_SET && !sim_used_r;
  endsequence

  property p_dt_range;
    @(posedge clk) disable iff (!resetn)
      dt_cyc_r >= tdg_pkg::DT_CNT_MIN;
  endproperty
  a_dt_range: assert property (p_dt_range)
    else $error("Deadtime count below one");

  property p_dt_sat;
    @(posedge clk) disable iff (!resetn)
      resetn && dt_sum[8] |=> dt_cyc_r == tdg_pkg::DT_CNT_MAX;
  endproperty
  a_dt_sat: assert property (p_dt_sat)
    else $error("Deadtime count not saturated");

  property p_dt_follow;
    @(posedge clk) disable iff (!resetn)
      resetn && !dt_sum[8] && dt_sum[7:0] != 8'h00
      |=> dt_cyc_r == $past(dt_sum[7:0]);
  endproperty
  a_dt_follow: assert property (p_dt_follow)
    else $error("Deadtime count differs from steps plus offset");

  property p_sim_once;
    @(posedge clk) disable iff (!resetn)
      $past(sim_used_r) |-> $stable(sim_en_r);
  endproperty
  a_sim_once: assert property (p_sim_once)
    else $error("Simultaneous mode changed twice");

  property p_sim_take;
    @(posedge clk) disable iff (!resetn)
      s_sim_arm ##1 !cmd_valid ##1 s_sim_set
      |=> sim_used_r && (sim_en_r == $past(cmd_data[0]));
  endproperty
  a_sim_take: assert property (p_sim_take)
    else $error("Armed simultaneous command not taken");

  property p_lock;
    @(posedge clk) disable iff (!resetn)
      $past(mode_lock_r) |-> $stable(mode_r);
  endproperty
  a_lock: assert property (p_lock)
    else $error("Locked mode changed");

  property p_mode_take;
    @(posedge clk) disable iff (!resetn)
      s_mode_cmd |=> (mode_r == $past(cmd_data[2:0]))
                     && (mode_lock_r == $past(cmd_data[7]));
  endproperty
  a_mode_take: assert property (p_mode_take)
    else $error("Mode command not taken");

  property p_no_blank_sim;
    @(posedge clk) disable iff (!resetn)
      sim_en_r |=> blank_cnt_r == 4'h0;
  endproperty
  a_no_blank_sim: assert property (p_no_blank_sim)
    else $error("Blanking active in simultaneous mode");

  property p_blank_load;
    @(posedge clk) disable iff (!resetn)
      resetn && (|ph_on) && !sim_en_r |=> blank_cnt_r == tdg_pkg::BLANK_CYC;
  endproperty
  a_blank_load: assert property (p_blank_load)
    else $error("Blanking not started on switching");

  property p_blank_mask;
    @(posedge clk) disable iff (!resetn)
      blank_cnt_r != 4'h0 |=> fault_report == 4'h0;
  endproperty
  a_blank_mask: assert property (p_blank_mask)
    else $error("Fault reported during blanking");

  property p_mask;
    @(posedge clk) disable iff (!resetn)
      resetn && blank_cnt_r == 4'h0
      |=> fault_report == $past(fault_in & mask_r);
  endproperty
  a_mask: assert property (p_mask)
    else $error("Fault report ignores mask");

  property p_overlap;
    @(posedge clk) disable iff (!resetn)
      !sim_en_r |=> (gate_out.hs & gate_out.ls) == 3'h0;
  endproperty
  a_overlap: assert property (p_overlap)
    else $error("Phase overlap at output");

  property p_full_on;
    @(posedge clk) disable iff (!resetn)
      resetn && mode_r.full_on_bypass_mode && !sim_en_r
      |=> ((gate_out.hs & ~$past(hs_s)) | (gate_out.ls & ~$past(ls_s)))
          == 3'h0;
  endproperty
  a_full_on: assert property (p_full_on)
    else $error("Full-on output without request");

  property p_status;
    @(posedge clk) disable iff (!resetn)
      resetn |=> status_out.dt_cycles == $past(dt_cyc_r);
  endproperty
  a_status: assert property (p_status)
    else $error("Status deadtime not current");

endmodule

//--- sim/tdg_mcu_model.sv
// Controller model driving the phase pins and the command strobe
`timescale 1ns/1ns
module tdg_mcu_model (
  input  wire logic         clk,
  output logic [2:0]        hs,
  output logic [2:0]        ls,
  output logic              cmd_valid,
  output tdg_pkg::tdg_cmd_e cmd_op,
  output logic [7:0]        cmd_data
);
  int n_edges = 0;
  int last_stim = 0;

  initial begin
    hs = 3'h0;
    ls = 3'h0;
    cmd_valid = 1'b0;
    cmd_op = tdg_pkg::TDG_CMD_NONE;
    cmd_data = 8'h00;
  end

  always @(posedge clk) n_edges <= n_edges + 1;

  task automatic pins(input logic [2:0] h, input logic [2:0] l);
    @(posedge clk);
    hs <= h;
    ls <= l;
    last_stim = n_edges;
  endtask

  task automatic cmd(input tdg_pkg::tdg_cmd_e op, input logic [7:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_data <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_op <= tdg_pkg::TDG_CMD_NONE;
    cmd_data <= ~d;
  endtask

  // Arm then set, guards against stray enables
  task automatic sim_enable(input logic en);
    cmd(tdg_pkg::TDG_CMD_SIM_ARM, 8'h00);
    cmd(tdg_pkg::TDG_CMD_SIM_SET, {7'h00, en});
  endtask

  // Low sides pulsed to charge the bootstrap
  task automatic boot_charge();
    pins(3'h0, 3'h7);
    repeat (10) @(posedge clk);
    pins(3'h0, 3'h0);
  endtask
endmodule

//--- sim/tdg_top_tb_top.sv
// Self-checking bench for the deadtime gate logic
`timescale 1ns/1ns
module tdg_top_tb_top;
  typedef struct packed {
    logic [5:0] g;
    logic [7:0] lo;
    logic [7:0] hi;
  } tdg_exp_s;
  logic                 clk;
  logic                 resetn;
  logic [2:0]           hs;
  logic [2:0]           ls;
  logic                 cmd_valid;
  tdg_pkg::tdg_cmd_e    cmd_op;
  logic [7:0]           cmd_data;
  logic [3:0]           fault_in;
  tdg_pkg::tdg_gate_s   gate_out;
  logic                 blank_out;
  logic [3:0]           fault_report;
  tdg_pkg::tdg_status_s status_out;
  tdg_exp_s             exp_q[$];
  tdg_exp_s             e;
  logic [5:0]           prev_g;
  logic                 blank_seen;
  logic [31:0]          rnd = 32'h000122A9;
  logic [7:0]           stp_tab[4] = '{8'h00, 8'hF0, 8'hFF, 8'h14};
  logic [7:0]           cal_tab[4] = '{8'h00, 8'h00, 8'h01, 8'h00};
  int                   errors = 0;
  int                   checks = 0;
  int                   lat;
  int                   lat_n;
  int                   lat_f;
  int                   x;

  tdg_mcu_model tdg_mcu_model_i (.clk(clk), .hs(hs), .ls(ls),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data));
  tdg_top tdg_top_i (.clk(clk), .resetn(resetn),
    .phase_high_side_input(hs), .phase_low_side_input(ls),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .fault_in(fault_in), .gate_out(gate_out), .blank_out(blank_out),
    .fault_report(fault_report), .status_out(status_out));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input string n, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic pin(input logic [5:0] g);
    tdg_mcu_model_i.pins(g[5:3], g[2:0]);
  endtask

  task automatic ex(input logic [5:0] g, input logic [7:0] lo,
                    input logic [7:0] hi);
    exp_q.push_back({g, lo, hi});
  endtask

  task automatic cmd(input tdg_pkg::tdg_cmd_e op, input logic [7:0] d);
    tdg_mcu_model_i.cmd(op, d);
    repeat (4) @(posedge clk);
  endtask

  task automatic settle();
    for (int i = 0; i < 300 && exp_q.size() > 0; i++) @(posedge clk);
    repeat (12) @(posedge clk);
    check("pending", 16'(exp_q.size()), 16'h0000);
  endtask

  task automatic toggle_ls(output int l);
    pin(6'h00);
    ex(6'h00, 8'h02, 8'h07);
    settle();
    l = lat;
    repeat (30) @(posedge clk);
    pin(6'h07);
    ex(6'h07, 8'h02, 8'h07);
    settle();
  endtask

  // ------------------------------------------------------------
  // Output watcher
  // ------------------------------------------------------------
  always @(negedge clk) begin
    if (tdg_mcu_model_i.n_edges > 5000) begin
      errors++;
      report_and_stop();
    end
    if (blank_out === 1'b1) blank_seen = 1'b1;
    check("blanking", 16'(status_out.blanking), 16'(blank_out));
    if (blank_out === 1'b1 && fault_report !== 4'h0)
      check("fault_blank", 16'(fault_report), 16'h0000);
    if (status_out.sim_enabled !== 1'b1 &&
        (gate_out.hs & gate_out.ls) !== 3'h0)
      check("overlap", 16'(gate_out.hs & gate_out.ls), 16'h0000);
    if (resetn === 1'b1 && gate_out !== prev_g) begin
      lat = tdg_mcu_model_i.n_edges - tdg_mcu_model_i.last_stim;
      if (exp_q.size() == 0) begin
        check("gate_extra", 16'(gate_out), 16'(prev_g));
      end else begin
        e = exp_q.pop_front();
        check("gate", 16'(gate_out), 16'(e.g));
        check("lat", 16'(lat >= e.lo && lat <= e.hi), 16'h0001);
      end
    end
    prev_g = gate_out;
  end

  initial begin
    resetn = 1'b0;
    fault_in = 4'h0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    check("dt_reset", 16'(status_out.dt_cycles), 16'h0010);
    foreach (stp_tab[i]) begin
      cmd(tdg_pkg::TDG_CMD_CAL, cal_tab[i]);
      cmd(tdg_pkg::TDG_CMD_DEADTIME, stp_tab[i]);
      x = stp_tab[i] * tdg_pkg::DT_STEP_CYC + cal_tab[i];
      x = (x < 1) ? 1 : (x > 255) ? 255 : x;
      check("dt_cycles", 16'(status_out.dt_cycles), 16'(x));
    end
    for (int k = 0; k < 4; k++) begin
      rnd = xs(rnd);
      cmd(tdg_pkg::TDG_CMD_MASK, {4'h0, rnd[3:0]});
      fault_in <= rnd[7:4];
      repeat (12) @(posedge clk);
      check("fault_rep", 16'(fault_report), 16'(rnd[3:0] & rnd[7:4]));
    end
    cmd(tdg_pkg::TDG_CMD_MASK, 8'h0F);
    fault_in <= 4'hF;
    pin(6'h38);
    repeat (30) @(posedge clk);
    pin(6'h00);
    repeat (10) @(posedge clk);
    check("boot0", 16'(status_out.boot_ready), 16'h0000);
    ex(6'h07, 8'h02, 8'h07);
    ex(6'h00, 8'h02, 8'h07);
    tdg_mcu_model_i.boot_charge();
    settle();
    check("boot1", 16'(status_out.boot_ready), 16'h0007);
    repeat (30) @(posedge clk);
    pin(6'h07);
    ex(6'h07, 8'h02, 8'h07);
    settle();
    blank_seen = 1'b0;
    pin(6'h38);
    ex(6'h00, 8'h02, 8'h07);
    ex(6'h38, 8'h15, 8'h1E);
    settle();
    check("blank", 16'(blank_seen), 16'h0001);
    pin(6'h00);
    ex(6'h00, 8'h02, 8'h07);
    settle();
    repeat (30) @(posedge clk);
    pin(6'h38);
    ex(6'h38, 8'h02, 8'h07);
    settle();
    pin(6'h07);
    ex(6'h00, 8'h02, 8'h07);
    ex(6'h07, 8'h15, 8'h1E);
    settle();
    toggle_ls(lat_n);
    cmd(tdg_pkg::TDG_CMD_MODE, 8'h04);
    toggle_ls(lat_f);
    check("full_on_bypass_mode_lat", 16'(lat_f), 16'(lat_n - 1));
    cmd(tdg_pkg::TDG_CMD_MODE, 8'h80);
    cmd(tdg_pkg::TDG_CMD_MODE, 8'h04);
    toggle_ls(lat_f);
    check("lock_lat", 16'(lat_f), 16'(lat_n));
    check("locked", 16'(status_out.mode_locked), 16'h0001);
    cmd(tdg_pkg::TDG_CMD_SIM_SET, 8'h01);
    check("sim_noarm", 16'(status_out.sim_enabled), 16'h0000);
    tdg_mcu_model_i.sim_enable(1'b1);
    repeat (4) @(posedge clk);
    check("sim_on",
          16'({status_out.sim_enabled, status_out.sim_used}), 16'h0003);
    tdg_mcu_model_i.sim_enable(1'b0);
    repeat (4) @(posedge clk);
    check("sim_once", 16'(status_out.sim_enabled), 16'h0001);
    blank_seen = 1'b0;
    toggle_ls(lat_f);
    check("sim_blank", 16'(blank_seen), 16'h0000);
    report_and_stop();
  end
endmodule
